/* File: core/spic_defines.svh */
// Notes on behaviour
// - Parallel or serial-only mode: CPU port register bits 5:0 do nothing; only 7:6 act.
// - Spanning state 00/01 drop, 10 drops but learns, 11 forwards and learns (default).
// - Serial+MII: bit 0 clear enables flow control; bit 5 then stops pause sending only.
// - Serial+MII: speed bit clear gives 100 Mbps, set gives 10 Mbps.
// - Bit 3 forces the CPU MII port up or down; up uses bits 2:0.
// - Untagged filter bit drops untagged frames, or security option handles them.
// - Tagged filter bit drops tagged frames, or security option handles them.
// - Bit 2 set stops source address learning on the port.
// - Bit 3 picks rate refresh period: 10 us when clear, 1 ms when set.
// - Bit 4 forces egress VLAN tag in tag-based mode; zero in port mode.
// - Bit 5 keeps VLAN tags unchanged, overriding the per-VLAN tag handling bit.
// - Violation: secure address on wrong port, or learning-off port with unknown/foreign address.
// - An entry is secure when static and its address bit 0 is one.
// - Address violations: 00 forward, 01 discard, 10 forward plus CPU, 11 CPU only.
// - Filtered untagged, filtered tagged, source-listed and destination-listed frames also violate.
// - Filter violations: security upper bit zero discards, one sends to CPU.
// - Second register per port at CPU base+2n and two-wire base+n, both read/write.
`ifndef SPIC_DEFINES_SVH
`define SPIC_DEFINES_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define SPIC_CPU_ECR2_BASE   16'h0001
`define SPIC_TWI_ECR2_BASE   12'h00a
`define SPIC_CPU_LINK_ADDR   16'h0010
`define SPIC_TWI_LINK_ADDR   12'h008

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SPIC_LINK_RST        8'hd0
`define SPIC_ECR2_RST        8'h00

// ----------------------------------------------------------------
// Field positions, CPU port link register
// ----------------------------------------------------------------
`define SPIC_L_FC_DIS        0
`define SPIC_L_HALF          1
`define SPIC_L_SPD10         2
`define SPIC_L_UP            3
`define SPIC_L_ASYM          5
`define SPIC_L_STP_HI        7
`define SPIC_L_STP_LO        6

// ----------------------------------------------------------------
// Field positions, ingress filter register
// ----------------------------------------------------------------
`define SPIC_F_UNTAG         0
`define SPIC_F_TAG           1
`define SPIC_F_NOLEARN       2
`define SPIC_F_RATE1MS       3
`define SPIC_F_FORCETAG      4
`define SPIC_F_KEEPTAG       5
`define SPIC_F_SEC_HI        7
`define SPIC_F_SEC_LO        6

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SPIC_CLK_MHZ         200
`define SPIC_T_SHORT_US      10
`define SPIC_T_LONG_MS       1

`endif

/* File: core/spic_pkg.sv */
package spic_pkg;

   typedef enum logic [1:0]
   {
      SPIC_STP_BLOCK  = 2'h0,
      SPIC_STP_LISTEN = 2'h1,
      SPIC_STP_LEARN  = 2'h2,
      SPIC_STP_FWD    = 2'h3
   } spic_stp_type;

   typedef enum logic [1:0]
   {
      SPIC_SEC_OFF     = 2'h0,
      SPIC_SEC_DISCARD = 2'h1,
      SPIC_SEC_COPY    = 2'h2,
      SPIC_SEC_CPU     = 2'h3
   } spic_sec_type;

   typedef enum logic [1:0]
   {
      SPIC_RSEL_NONE = 2'h0,
      SPIC_RSEL_MEM  = 2'h1,
      SPIC_RSEL_LINK = 2'h2
   } spic_rsel_type;

endpackage : spic_pkg

/* File: core/spic_reg_mem.sv */
`timescale 1ns/1ps
`include "spic_defines.svh"

module spic_reg_mem #(
   parameter int N  = 10,
   parameter int AW = 4
) (
   // Clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 rst,
   // Write port A, wins on the same entry
   input  wire logic                 wa_en,
   input  wire logic [AW-1:0]        wa_addr,
   input  wire logic [7:0]           wa_data,
   // Write port B
   input  wire logic                 wb_en,
   input  wire logic [AW-1:0]        wb_addr,
   input  wire logic [7:0]           wb_data,
   // Read ports, data registered
   input  wire logic [AW-1:0]        ra_addr,
   output logic      [7:0]           ra_data,
   input  wire logic [AW-1:0]        rb_addr,
   output logic      [7:0]           rb_data,
   // Whole contents for the frame logic
   output logic      [N-1:0][7:0]    cfg_all
);

   logic [N-1:0][7:0] mem_r;
   logic [N-1:0][7:0] mem_nxt;
   logic [7:0]        ra_nxt;
   logic [7:0]        rb_nxt;

   genvar gi;
   generate
      for (gi = 0; gi < N; gi++)
      begin : g_ent
         always_comb
         begin
            mem_nxt[gi] = mem_r[gi];
            if (wb_en && (wb_addr == AW'(gi)))
               mem_nxt[gi] = wb_data;
            if (wa_en && (wa_addr == AW'(gi)))
               mem_nxt[gi] = wa_data;
         end
      end
   endgenerate

   always_comb
   begin
      ra_nxt = 8'h00;
      rb_nxt = 8'h00;
      if (32'(ra_addr) < N)
         ra_nxt = mem_r[ra_addr];
      if (32'(rb_addr) < N)
         rb_nxt = mem_r[rb_addr];
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         mem_r   <= {N{`SPIC_ECR2_RST}};
         ra_data <= 8'h00;
         rb_data <= 8'h00;
      end
      else
      begin
         mem_r   <= mem_nxt;
         ra_data <= ra_nxt;
         rb_data <= rb_nxt;
      end
   end

   assign cfg_all = mem_r;

endmodule : spic_reg_mem

/* File: core/spic_top.sv */
`timescale 1ns/1ps
`include "spic_defines.svh"

module spic_top #(
   parameter int NPORTS   = 10,
   parameter int CPU_PORT = 8,
   parameter int PW       = 4,
   parameter int LONG_CYC = `SPIC_T_LONG_MS * 1000 * `SPIC_CLK_MHZ
) (
   // Clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 rst,
   // Configuration levels
   input  wire logic                 mgmt_mii_mode,
   input  wire logic                 vlan_mode_select,
   // CPU register access
   input  wire logic [15:0]          cpu_addr,
   input  wire logic                 cpu_wr,
   input  wire logic                 cpu_rd,
   input  wire logic [7:0]           cpu_wdata,
   output logic      [7:0]           cpu_rdata,
   output logic                      cpu_rvalid,
   // Two-wire register access
   input  wire logic [11:0]          twi_addr,
   input  wire logic                 twi_wr,
   input  wire logic                 twi_rd,
   input  wire logic [7:0]           twi_wdata,
   output logic      [7:0]           twi_rdata,
   output logic                      twi_rvalid,
   // Frame descriptor
   input  wire logic                 frm_valid,
   input  wire logic [PW-1:0]        frm_port,
   input  wire logic                 frm_tagged,
   input  wire logic                 sa_found,
   input  wire logic                 sa_static,
   input  wire logic                 sa_secure_bit,
   input  wire logic [PW-1:0]        sa_port,
   input  wire logic                 sa_filter_hit,
   input  wire logic                 da_filter_hit,
   input  wire logic                 per_vlan_map_word3_tag,
   // Frame verdict
   output logic                      vd_valid,
   output logic                      vd_forward,
   output logic                      vd_to_cpu,
   output logic                      vd_learn,
   output logic                      vd_violation,
   output logic                      vd_force_tag,
   output logic                      vd_tag_edit,
   // CPU MII port setup
   output logic                      cpu_link_up,
   output logic                      cpu_speed_10,
   output logic                      cpu_full_duplex,
   output logic                      cpu_pause_tx_en,
   output logic                      cpu_pause_rx_en,
   output logic                      cpu_fwd_en,
   output logic                      cpu_learn_en,
   // Rate control refresh ticks
   output logic      [NPORTS-1:0]    rate_refresh
);

   localparam int SHORT_CYC = `SPIC_T_SHORT_US * `SPIC_CLK_MHZ;
   // Both dividers share one width, so it must hold the larger period
   localparam int CW        = $clog2(((LONG_CYC > SHORT_CYC) ? LONG_CYC : SHORT_CYC) + 1);

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   function automatic logic [PW:0] cpu_dec(input logic [15:0] a);
      logic [15:0] d;
      d = a - `SPIC_CPU_ECR2_BASE;
      cpu_dec = {1'b0, d[PW:1]};
      if ((a >= `SPIC_CPU_ECR2_BASE) && !d[0] && (32'(d[15:1]) < NPORTS))
         cpu_dec[PW] = 1'b1;
   endfunction : cpu_dec

   function automatic logic [PW:0] twi_dec(input logic [11:0] a);
      logic [11:0] d;
      d = a - `SPIC_TWI_ECR2_BASE;
      twi_dec = {1'b0, d[PW-1:0]};
      if ((a >= `SPIC_TWI_ECR2_BASE) && (32'(d) < NPORTS))
         twi_dec[PW] = 1'b1;
   endfunction : twi_dec

   logic [PW:0] cpu_hit;
   logic [PW:0] twi_hit;
   logic        cpu_link_hit;
   logic        twi_link_hit;

   assign cpu_hit      = cpu_dec(cpu_addr);
   assign twi_hit      = twi_dec(twi_addr);
   assign cpu_link_hit = (cpu_addr == `SPIC_CPU_LINK_ADDR);
   assign twi_link_hit = (twi_addr == `SPIC_TWI_LINK_ADDR);

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   logic [NPORTS-1:0][7:0] cfg_all;
   logic [7:0]             mem_cpu_rd;
   logic [7:0]             mem_twi_rd;
   logic [7:0]             link_r;
   logic [7:0]             link_nxt;

   spic_reg_mem #(
      .N  (NPORTS),
      .AW (PW)
   ) u_mem (
      .clk_sys (clk_sys),
      .rst     (rst),
      .wa_en   (cpu_wr & cpu_hit[PW]),
      .wa_addr (cpu_hit[PW-1:0]),
      .wa_data (cpu_wdata),
      .wb_en   (twi_wr & twi_hit[PW]),
      .wb_addr (twi_hit[PW-1:0]),
      .wb_data (twi_wdata),
      .ra_addr (cpu_hit[PW-1:0]),
      .ra_data (mem_cpu_rd),
      .rb_addr (twi_hit[PW-1:0]),
      .rb_data (mem_twi_rd),
      .cfg_all (cfg_all)
   );

   // CPU write wins when both sides hit the same register
   always_comb
   begin
      link_nxt = link_r;
      if (twi_wr && twi_link_hit)
         link_nxt = twi_wdata;
      if (cpu_wr && cpu_link_hit)
         link_nxt = cpu_wdata;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         link_r <= `SPIC_LINK_RST;
      else
         link_r <= link_nxt;
   end

   // ----------------------------------------------------------------
   // Read pipeline, two cycles
   // ----------------------------------------------------------------
   spic_pkg::spic_rsel_type cpu_sel_r;
   spic_pkg::spic_rsel_type cpu_sel_nxt;
   spic_pkg::spic_rsel_type twi_sel_r;
   spic_pkg::spic_rsel_type twi_sel_nxt;
   logic                    cpu_rd1_r;
   logic                    twi_rd1_r;
   logic [7:0]              cpu_rdata_nxt;
   logic [7:0]              twi_rdata_nxt;

   always_comb
   begin
      cpu_sel_nxt = spic_pkg::SPIC_RSEL_NONE;
      twi_sel_nxt = spic_pkg::SPIC_RSEL_NONE;
      if (cpu_hit[PW])
         cpu_sel_nxt = spic_pkg::SPIC_RSEL_MEM;
      else if (cpu_link_hit)
         cpu_sel_nxt = spic_pkg::SPIC_RSEL_LINK;
      if (twi_hit[PW])
         twi_sel_nxt = spic_pkg::SPIC_RSEL_MEM;
      else if (twi_link_hit)
         twi_sel_nxt = spic_pkg::SPIC_RSEL_LINK;
      case (cpu_sel_r)
         spic_pkg::SPIC_RSEL_MEM:  cpu_rdata_nxt = mem_cpu_rd;
         spic_pkg::SPIC_RSEL_LINK: cpu_rdata_nxt = link_r;
         default:                  cpu_rdata_nxt = 8'h00;
      endcase
      case (twi_sel_r)
         spic_pkg::SPIC_RSEL_MEM:  twi_rdata_nxt = mem_twi_rd;
         spic_pkg::SPIC_RSEL_LINK: twi_rdata_nxt = link_r;
         default:                  twi_rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         cpu_sel_r  <= spic_pkg::SPIC_RSEL_NONE;
         twi_sel_r  <= spic_pkg::SPIC_RSEL_NONE;
         cpu_rd1_r  <= 1'b0;
         twi_rd1_r  <= 1'b0;
         cpu_rdata  <= 8'h00;
         twi_rdata  <= 8'h00;
         cpu_rvalid <= 1'b0;
         twi_rvalid <= 1'b0;
      end
      else
      begin
         cpu_sel_r  <= cpu_sel_nxt;
         twi_sel_r  <= twi_sel_nxt;
         cpu_rd1_r  <= cpu_rd;
         twi_rd1_r  <= twi_rd;
         cpu_rdata  <= cpu_rd1_r ? cpu_rdata_nxt : cpu_rdata;
         twi_rdata  <= twi_rd1_r ? twi_rdata_nxt : twi_rdata;
         cpu_rvalid <= cpu_rd1_r;
         twi_rvalid <= twi_rd1_r;
      end
   end

   // ----------------------------------------------------------------
   // CPU port link and spanning state
   // ----------------------------------------------------------------
   spic_pkg::spic_stp_type stp;
   logic [6:0]             mii_nxt;
   logic [6:0]             mii_r;

   assign stp = spic_pkg::spic_stp_type'(link_r[`SPIC_L_STP_HI:`SPIC_L_STP_LO]);

   always_comb
   begin
      mii_nxt    = 7'h00;
      mii_nxt[5] = (stp == spic_pkg::SPIC_STP_FWD);
      mii_nxt[6] = (stp == spic_pkg::SPIC_STP_FWD) || (stp == spic_pkg::SPIC_STP_LEARN);
      // Low bits only act with the MII attached
      if (mgmt_mii_mode && link_r[`SPIC_L_UP])
      begin
         mii_nxt[0] = 1'b1;
         mii_nxt[1] = link_r[`SPIC_L_SPD10];
         mii_nxt[2] = !link_r[`SPIC_L_HALF];
         mii_nxt[3] = !link_r[`SPIC_L_FC_DIS] && !link_r[`SPIC_L_ASYM];
         mii_nxt[4] = !link_r[`SPIC_L_FC_DIS];
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         mii_r <= 7'h00;
      else
         mii_r <= mii_nxt;
   end

   assign cpu_link_up     = mii_r[0];
   assign cpu_speed_10    = mii_r[1];
   assign cpu_full_duplex = mii_r[2];
   assign cpu_pause_tx_en = mii_r[3];
   assign cpu_pause_rx_en = mii_r[4];
   assign cpu_fwd_en      = mii_r[5];
   assign cpu_learn_en    = mii_r[6];

   // ----------------------------------------------------------------
   // Rate refresh dividers
   // ----------------------------------------------------------------
   logic [CW-1:0]     cnt_s_r;
   logic [CW-1:0]     cnt_s_nxt;
   logic [CW-1:0]     cnt_l_r;
   logic [CW-1:0]     cnt_l_nxt;
   logic              tick_s;
   logic              tick_l;
   logic [NPORTS-1:0] refresh_nxt;

   assign tick_s = (cnt_s_r == CW'(SHORT_CYC - 1));
   assign tick_l = (cnt_l_r == CW'(LONG_CYC - 1));

   always_comb
   begin
      cnt_s_nxt = tick_s ? '0 : cnt_s_r + CW'(1);
      cnt_l_nxt = tick_l ? '0 : cnt_l_r + CW'(1);
   end

   genvar gp;
   generate
      for (gp = 0; gp < NPORTS; gp++)
      begin : g_rate
         assign refresh_nxt[gp] = cfg_all[gp][`SPIC_F_RATE1MS] ? tick_l : tick_s;
      end
   endgenerate

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         cnt_s_r      <= '0;
         cnt_l_r      <= '0;
         rate_refresh <= '0;
      end
      else
      begin
         cnt_s_r      <= cnt_s_nxt;
         cnt_l_r      <= cnt_l_nxt;
         rate_refresh <= refresh_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Frame verdict
   // ----------------------------------------------------------------
   logic [7:0]             cfg;
   spic_pkg::spic_sec_type sec;
   logic                   v_addr;
   logic                   v_filt;
   logic [6:0]             vd_nxt;
   logic [6:0]             vd_r;

   always_comb
   begin
      cfg = 8'h00;
      if (32'(frm_port) < NPORTS)
         cfg = cfg_all[frm_port];
      sec    = spic_pkg::spic_sec_type'(cfg[`SPIC_F_SEC_HI:`SPIC_F_SEC_LO]);
      v_addr = (sa_found && sa_static && sa_secure_bit && (sa_port != frm_port))
               || (cfg[`SPIC_F_NOLEARN] && (!sa_found || (sa_port != frm_port)));
      v_filt = (cfg[`SPIC_F_UNTAG] && !frm_tagged)
               || (cfg[`SPIC_F_TAG] && frm_tagged)
               || sa_filter_hit || da_filter_hit;
      vd_nxt    = 7'h00;
      vd_nxt[0] = frm_valid;
      vd_nxt[1] = 1'b1;
      vd_nxt[3] = !cfg[`SPIC_F_NOLEARN];
      vd_nxt[4] = v_addr || v_filt;
      vd_nxt[5] = cfg[`SPIC_F_FORCETAG] && vlan_mode_select;
      vd_nxt[6] = per_vlan_map_word3_tag && !cfg[`SPIC_F_KEEPTAG];
      if (v_filt)
      begin
         vd_nxt[1] = 1'b0;
         vd_nxt[2] = cfg[`SPIC_F_SEC_HI];
      end
      else if (v_addr)
      begin
         case (sec)
            spic_pkg::SPIC_SEC_DISCARD: vd_nxt[1] = 1'b0;
            spic_pkg::SPIC_SEC_COPY:    vd_nxt[2] = 1'b1;
            spic_pkg::SPIC_SEC_CPU:
            begin
               vd_nxt[1] = 1'b0;
               vd_nxt[2] = 1'b1;
            end
            default:                    vd_nxt[1] = 1'b1;
         endcase
      end
      // CPU port spanning state gates its own ingress
      if (32'(frm_port) == CPU_PORT)
      begin
         if (!mii_nxt[5])
         begin
            vd_nxt[1] = 1'b0;
            vd_nxt[2] = 1'b0;
         end
         vd_nxt[3] = vd_nxt[3] && mii_nxt[6];
      end
      if (!frm_valid)
         vd_nxt = 7'h00;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         vd_r <= 7'h00;
      else
         vd_r <= vd_nxt;
   end

   assign vd_valid     = vd_r[0];
   assign vd_forward   = vd_r[1];
   assign vd_to_cpu    = vd_r[2];
   assign vd_learn     = vd_r[3];
   assign vd_violation = vd_r[4];
   assign vd_force_tag = vd_r[5];
   assign vd_tag_edit  = vd_r[6];

endmodule : spic_top

/* File: tb/spic_monitor.sv */
`timescale 1ns/1ps

module spic_monitor #(
   parameter int PW       = 4,
   parameter int CPU_PORT = 8
) (
   // Clock, reset and modes
   input logic          clk_sys,
   input logic          rst,
   input logic          mgmt_mii_mode,
   input logic          vlan_mode_select,
   // Register reads
   input logic          cpu_rd,
   input logic          cpu_rvalid,
   input logic          twi_rd,
   input logic          twi_rvalid,
   // Frame and verdict
   input logic          frm_valid,
   input logic [PW-1:0] frm_port,
   input logic          sa_filter_hit,
   input logic          da_filter_hit,
   input logic          per_vlan_map_word3_tag,
   input logic          vd_valid,
   input logic          vd_forward,
   input logic          vd_to_cpu,
   input logic          vd_violation,
   input logic          vd_force_tag,
   input logic          vd_tag_edit,
   // CPU MII setup
   input logic          cpu_link_up,
   input logic          cpu_speed_10,
   input logic          cpu_full_duplex,
   input logic          cpu_pause_tx_en,
   input logic          cpu_pause_rx_en,
   input logic          cpu_fwd_en
);

   default clocking mon_cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   // ----------
   // Properties
   // ----------
   verdict_next_a: assert property (frm_valid |=> vd_valid)
      else $error("verdict missing");
   filter_hit_a: assert property (frm_valid && (sa_filter_hit || da_filter_hit)
      |=> vd_violation && !vd_forward) else $error("filtered frame forwarded");
   force_tag_a: assert property (frm_valid && !vlan_mode_select |=> !vd_force_tag)
      else $error("tag forced in port mode");
   tag_keep_a: assert property (frm_valid && !per_vlan_map_word3_tag |=> !vd_tag_edit)
      else $error("tag edited without map bit");
   cpu_read_a: assert property (cpu_rd |-> ##2 cpu_rvalid)
      else $error("cpu read unanswered");
   twi_read_a: assert property (twi_rd |-> ##2 twi_rvalid)
      else $error("two-wire read unanswered");
   pause_asym_a: assert property (cpu_pause_tx_en |-> cpu_pause_rx_en && cpu_link_up)
      else $error("pause send without receive");
   link_down_a: assert property (!cpu_link_up |-> !(cpu_speed_10 || cpu_full_duplex || cpu_pause_rx_en))
      else $error("setup shown while down");
   serial_mode_a: assert property (!mgmt_mii_mode ##1 !mgmt_mii_mode |-> !cpu_link_up)
      else $error("link up in serial-only mode");
   cpu_block_a: assert property (frm_valid && frm_port == PW'(CPU_PORT) && !cpu_fwd_en ##1 !cpu_fwd_en
      |-> !vd_forward && !vd_to_cpu) else $error("blocked cpu port frame passed");

   cover property (frm_valid && frm_port == PW'(CPU_PORT));
   cover property (vd_violation && vd_to_cpu);
   cover property (cpu_link_up && cpu_speed_10);

endmodule : spic_monitor

bind spic_top spic_monitor #(.PW(PW), .CPU_PORT(CPU_PORT)) u_mon
(
   .clk_sys, .rst, .mgmt_mii_mode, .vlan_mode_select, .cpu_rd, .cpu_rvalid, .twi_rd, .twi_rvalid,
   .frm_valid, .frm_port, .sa_filter_hit, .da_filter_hit, .per_vlan_map_word3_tag, .vd_valid,
   .vd_forward, .vd_to_cpu, .vd_violation, .vd_force_tag, .vd_tag_edit, .cpu_link_up, .cpu_speed_10,
   .cpu_full_duplex, .cpu_pause_tx_en, .cpu_pause_rx_en, .cpu_fwd_en
);

/* File: tb/testbench.sv */
`timescale 1ns/1ps

module testbench;

   // -------
   // Signals
   // -------
   typedef struct packed
   {
      logic [7:0] cfg;
      logic [6:0] f;
      logic [3:0] sap;
      logic [5:0] exp;
   } spic_row_type;

   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic        mgmt_mii_mode = 1'b0;
   logic        vlan_mode_select = 1'b0;
   logic        cpu_wr = 1'b0, cpu_rd = 1'b0, twi_wr = 1'b0, twi_rd = 1'b0, frm_valid = 1'b0;
   logic [15:0] cpu_addr = 16'h0000;
   logic [11:0] twi_addr = 12'h000;
   logic [7:0]  cpu_wdata = 8'h00, twi_wdata = 8'h00, cpu_rdata, twi_rdata;
   logic [3:0]  frm_port = 4'h0, sa_port = 4'h0;
   logic [6:0]  ff = 7'h00;
   logic        cpu_rvalid, twi_rvalid, vd_valid, cpu_fwd_en, cpu_learn_en;
   logic [9:0]  rate_refresh;
   wire  [5:0]  vd;
   wire  [4:0]  mii;
   int          errors = 0;
   int          tests_run = 0;
   int          n;
   logic [7:0]  lv [5] = '{8'hdc, 8'hf8, 8'hd9, 8'hd0, 8'hdc};
   logic [4:0]  le [5] = '{5'h1f, 5'h15, 5'h14, 5'h00, 5'h00};
   // Frame bits: tagged, found, static, secure, sa filter, da filter, map tag
   spic_row_type rows [13] = '{
      '{8'h00, 7'h21, 4'h1, 6'h29}, '{8'h01, 7'h20, 4'h1, 6'h0c}, '{8'hc2, 7'h60, 4'h1, 6'h1c},
      '{8'h80, 7'h24, 4'h1, 6'h1c}, '{8'h40, 7'h22, 4'h1, 6'h0c}, '{8'h40, 7'h38, 4'h2, 6'h0c},
      '{8'h80, 7'h38, 4'h2, 6'h3c}, '{8'hc0, 7'h38, 4'h2, 6'h1c}, '{8'h00, 7'h38, 4'h2, 6'h2c},
      '{8'h44, 7'h00, 4'h1, 6'h04}, '{8'h84, 7'h20, 4'h1, 6'h20}, '{8'h30, 7'h21, 4'h1, 6'h2a},
      '{8'h40, 7'h28, 4'h2, 6'h28}};

   spic_top #(.LONG_CYC(40)) uut
   (
      .clk_sys, .rst, .mgmt_mii_mode, .vlan_mode_select,
      .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata, .cpu_rdata, .cpu_rvalid,
      .twi_addr, .twi_wr, .twi_rd, .twi_wdata, .twi_rdata, .twi_rvalid,
      .frm_valid, .frm_port, .frm_tagged(ff[6]), .sa_found(ff[5]), .sa_static(ff[4]),
      .sa_secure_bit(ff[3]), .sa_port, .sa_filter_hit(ff[2]), .da_filter_hit(ff[1]),
      .per_vlan_map_word3_tag(ff[0]), .vd_valid, .vd_forward(vd[5]), .vd_to_cpu(vd[4]),
      .vd_learn(vd[3]), .vd_violation(vd[2]), .vd_force_tag(vd[1]), .vd_tag_edit(vd[0]),
      .cpu_link_up(mii[4]), .cpu_speed_10(mii[3]), .cpu_full_duplex(mii[2]),
      .cpu_pause_tx_en(mii[1]), .cpu_pause_rx_en(mii[0]), .cpu_fwd_en, .cpu_learn_en, .rate_refresh
   );

   // -----
   // Tasks
   // -----
   task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         errors++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic cwr(logic [15:0] a, logic [7:0] d);
      @(posedge clk_sys);
      cpu_wr    <= 1'b1;
      cpu_addr  <= a;
      cpu_wdata <= d;
      @(posedge clk_sys);
      cpu_wr <= 1'b0;
   endtask : cwr

   task automatic twr(logic [11:0] a, logic [7:0] d);
      @(posedge clk_sys);
      twi_wr    <= 1'b1;
      twi_addr  <= a;
      twi_wdata <= d;
      @(posedge clk_sys);
      twi_wr <= 1'b0;
   endtask : twr

   task automatic rd(logic t, logic [15:0] a, logic [7:0] e);
      @(posedge clk_sys);
      cpu_rd   <= !t;
      twi_rd   <= t;
      cpu_addr <= a;
      twi_addr <= a[11:0];
      @(posedge clk_sys);
      cpu_rd <= 1'b0;
      twi_rd <= 1'b0;
      #1;
      for (n = 0; n < 4 && (t ? twi_rvalid : cpu_rvalid) !== 1'b1; n++)
         @(posedge clk_sys) #1;
      check("read", {n < 4, t ? twi_rdata : cpu_rdata}, {1'b1, e});
   endtask : rd

   task automatic fr(logic [3:0] p, logic [6:0] f, logic [3:0] sp, logic [5:0] e);
      @(posedge clk_sys);
      frm_valid <= 1'b1;
      frm_port  <= p;
      ff        <= f;
      sa_port   <= sp;
      @(posedge clk_sys);
      frm_valid <= 1'b0;
      #1;
      check("verdict", {vd_valid, vd}, {1'b1, e});
   endtask : fr

   task automatic period(int b, int e);
      @(posedge clk_sys) #1;
      for (n = 0; n < 5000 && rate_refresh[b] !== 1'b1; n++)
         @(posedge clk_sys) #1;
      @(posedge clk_sys) #1;
      for (n = 1; n < 5000 && rate_refresh[b] !== 1'b1; n++)
         @(posedge clk_sys) #1;
      check("refresh period", 16'(n), 16'(e));
   endtask : period

   task automatic summarize();
      if (errors == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize

   initial
      forever #2.5 clk_sys = ~clk_sys;

   initial
   begin
      #100000;
      errors++;
      summarize();
   end

   initial
   begin
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys) #1;
      check("stp enables", {cpu_fwd_en, cpu_learn_en}, 2'h3);
      check("idle outputs", {vd_valid, vd, mii}, 12'h000);
      rd(1'b0, 16'h0010, 8'hd0);
      rd(1'b1, 16'h0008, 8'hd0);
      rd(1'b1, 16'h000a, 8'h00);
      @(posedge clk_sys);
      vlan_mode_select <= 1'b1;
      foreach (rows[i])
      begin
         cwr(16'h0003, rows[i].cfg);
         fr(4'h1, rows[i].f, rows[i].sap, rows[i].exp);
      end
      @(posedge clk_sys);
      vlan_mode_select <= 1'b0;
      for (int s = 0; s < 4; s++)
      begin
         cwr(16'h0010, {s[1:0], 6'h10});
         @(posedge clk_sys) #1;
         check("stp enables", {cpu_fwd_en, cpu_learn_en}, {s == 3, s > 1});
         fr(4'h8, 7'h20, 4'h8, {s == 3, 1'b0, s > 1, 3'h0});
      end
      for (int k = 0; k < 5; k++)
      begin
         @(posedge clk_sys);
         mgmt_mii_mode <= (k != 4);
         cwr(16'h0010, lv[k]);
         repeat (2) @(posedge clk_sys);
         #1;
         check("mii setup", mii, le[k]);
      end
      twr(12'h013, 8'ha5);
      rd(1'b0, 16'h0013, 8'ha5);
      cwr(16'h0015, 8'h5a);
      twr(12'h014, 8'h5a);
      rd(1'b0, 16'h0015, 8'h00);
      rd(1'b1, 16'h0014, 8'h00);
      fork
         cwr(16'h0001, 8'h11);
         twr(12'h00a, 8'h22);
      join
      rd(1'b1, 16'h000a, 8'h11);
      cwr(16'h0001, 8'h08);
      period(0, 40);
      period(1, 2000);
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      rd(1'b0, 16'h0001, 8'h00);
      rd(1'b1, 16'h0008, 8'hd0);
      summarize();
   end

endmodule : testbench
